// file: pkg/bmmd_pkg.sv
// package for the banked memory map decoder: map constants and bus carriers
package bmmd_pkg;
	localparam int unsigned BMMD_PC_W = 13;
	localparam int unsigned BMMD_PROG_AW = 11;
	localparam int unsigned BMMD_PROG_DW = 14;
	localparam int unsigned BMMD_PROG_DEPTH = 2048;
	localparam logic [12:0] BMMD_PROG_LAST = 13'h07ff;
	localparam logic [12:0] BMMD_RESET_VECTOR = 13'h0000;
	localparam logic [12:0] BMMD_IRQ_VECTOR = 13'h0004;
	localparam int unsigned BMMD_DATA_AW = 8;
	localparam int unsigned BMMD_OFS_W = 7;
	localparam logic [6:0] BMMD_BANK_LAST_OFS = 7'h7f;
	localparam logic [6:0] BMMD_OFS_INDIRECT = 7'h00;
	localparam logic [6:0] BMMD_OFS_PCL = 7'h02;
	localparam logic [6:0] BMMD_OFS_STATUS = 7'h03;
	localparam logic [6:0] BMMD_OFS_POINTER = 7'h04;
	localparam logic [6:0] BMMD_OFS_PCUB = 7'h0a;
	localparam logic [6:0] BMMD_GP_LOW_OFS = 7'h20;
	localparam logic [7:0] BMMD_GP0_FIRST = 8'h20;
	localparam logic [7:0] BMMD_GP0_LAST = 8'h7f;
	localparam logic [7:0] BMMD_GP1_FIRST = 8'ha0;
	localparam logic [7:0] BMMD_GP1_LAST = 8'hbf;
	localparam int unsigned BMMD_GP_WORDS = 128;
	localparam int unsigned BMMD_BANK_HI_BIT = 6;
	localparam int unsigned BMMD_BANK_LO_BIT = 5;
	localparam logic [7:0] BMMD_STATUS_RESET = 8'h18;
	localparam logic [7:0] BMMD_PCL_RESET = 8'h00;
	localparam logic [4:0] BMMD_PCUB_RESET = 5'h00;
	localparam logic [7:0] BMMD_POINTER_RESET = 8'h00;

	typedef struct packed {
		logic en;
		logic we;
		logic indirect;
		logic [6:0] ofs;
		logic [7:0] wdata;
	} bmmd_data_req_s;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} bmmd_data_rsp_s;

	typedef struct packed {
		logic load;
		logic [12:0] target;
		logic advance;
		logic irq;
	} bmmd_pc_ctl_s;
endpackage

// file: design/bmmd_prog_mem.sv
// program store: 2K x 14 words on its own bus
`timescale 1ns/100ps
module bmmd_prog_mem (
	input wire logic clk,
	input wire logic [bmmd_pkg::BMMD_PC_W-1:0] pc,
	input wire logic load_en,
	input wire logic [bmmd_pkg::BMMD_PROG_AW-1:0] load_addr,
	input wire logic [bmmd_pkg::BMMD_PROG_DW-1:0] load_data,
	output logic [bmmd_pkg::BMMD_PROG_DW-1:0] instr
);
	import bmmd_pkg::*;
	logic [BMMD_PROG_DW-1:0] store [0:BMMD_PROG_DEPTH-1];
	logic [BMMD_PROG_AW-1:0] fetch_addr;

	// high counter bits are dropped, so fetches past 07ffh wrap
	assign fetch_addr = pc[BMMD_PROG_AW-1:0];

	always_ff @(posedge clk) begin
		if (load_en) begin
			store[load_addr] <= load_data;
		end
	end

	// no reset on a ram read port; contents are undefined until loaded
	always_ff @(posedge clk) begin
		instr <= store[fetch_addr];
	end
endmodule

// file: design/bmmd_decoder.sv
// banked memory map decoder: program counter, core registers and data banks
// What this block does
// - separate program and data buses each cycle
// - 13-bit counter over 2K x 14 store
// - program store spans 0000h to 07FFh
// - fetch past top wraps into store
// - reset to 0000h, interrupt to 0004h
// - status bits 6:5 select data bank
// - each bank holds 128 byte offsets
// - low offsets registers, upper offsets ram (bank 1 ram only at offsets 20h-3Fh)
// - core registers mirrored in both banks
// - direct or pointer-based indirect access
`timescale 1ns/100ps
module bmmd_decoder (
	input wire logic clk,
	input wire logic rst_n,
	input wire bmmd_pkg::bmmd_pc_ctl_s pc_ctl,
	output logic [bmmd_pkg::BMMD_PC_W-1:0] pc,
	output logic [bmmd_pkg::BMMD_PROG_DW-1:0] instr,
	input wire logic prog_load_en,
	input wire logic [bmmd_pkg::BMMD_PROG_AW-1:0] prog_load_addr,
	input wire logic [bmmd_pkg::BMMD_PROG_DW-1:0] prog_load_data,
	input wire bmmd_pkg::bmmd_data_req_s data_req,
	output bmmd_pkg::bmmd_data_rsp_s data_rsp,
	input wire logic status_flags_we,
	input wire logic [4:0] status_flags_in,
	output logic [7:0] core_status,
	output logic [7:0] indirect_pointer,
	output logic [7:0] periph_addr,
	output logic periph_we,
	output logic periph_re,
	output logic [7:0] periph_wdata,
	input wire logic [7:0] periph_rdata,
	input wire logic periph_hit
);
	import bmmd_pkg::*;

	typedef enum logic [1:0] {
		BMMD_SPACE_CORE = 2'b01,
		BMMD_SPACE_OTHER = 2'b10
	} bmmd_space_e;

	logic [7:0] gp_ram [0:BMMD_GP_WORDS-1];
	logic [4:0] program_counter_upper_buffer;
	logic [7:0] eff_addr;
	logic [6:0] eff_ofs;
	logic bank_select_high;
	logic bank_select_low;
	logic is_gp;
	logic is_core;
	logic is_periph;
	logic acc_rd;
	logic acc_wr;
	logic [6:0] ram_idx;
	logic [7:0] next_rdata;
	logic [BMMD_PC_W-1:0] next_pc;
	bmmd_space_e space;

	// bank 1 ram A0h-BFh shares no cells with bank 0 20h-7Fh
	function automatic logic gp_hit(input logic [7:0] a);
		gp_hit = (a >= BMMD_GP0_FIRST && a <= BMMD_GP0_LAST) ||
			(a >= BMMD_GP1_FIRST && a <= BMMD_GP1_LAST);
	endfunction

	// bank 0 ram at index 20h-7fh, bank 1 ram folded into index 00h-1fh
	function automatic logic [6:0] gp_index(input logic [7:0] a);
		gp_index = a[7] ? {2'b00, a[4:0]} : a[6:0];
	endfunction

	assign bank_select_high = core_status[BMMD_BANK_HI_BIT];
	assign bank_select_low = core_status[BMMD_BANK_LO_BIT];

	// the upper bank bit is not in the 8-bit map; banks 2 and 3 fall off it
	always_comb begin
		if (data_req.indirect || data_req.ofs == BMMD_OFS_INDIRECT) begin
			eff_addr = indirect_pointer;
		end else begin
			eff_addr = {bank_select_low, data_req.ofs};
		end
	end

	assign eff_ofs = eff_addr[BMMD_OFS_W-1:0];
	assign acc_rd = data_req.en && !data_req.we && !bank_select_high;
	assign acc_wr = data_req.en && data_req.we && !bank_select_high;
	assign is_gp = gp_hit(eff_addr);
	// pointer aimed at the indirect slot itself reaches no storage
	assign is_core = eff_ofs == BMMD_OFS_PCL || eff_ofs == BMMD_OFS_STATUS ||
		eff_ofs == BMMD_OFS_POINTER || eff_ofs == BMMD_OFS_PCUB;
	assign space = is_core ? BMMD_SPACE_CORE : BMMD_SPACE_OTHER;
	assign ram_idx = gp_index(eff_addr);

	assign periph_addr = eff_addr;
	assign periph_wdata = data_req.wdata;
	// the indirect slot has no storage, so it never reaches a peripheral either
	assign is_periph = !is_core && !is_gp && eff_ofs < BMMD_GP_LOW_OFS &&
		eff_ofs != BMMD_OFS_INDIRECT;
	assign periph_we = acc_wr && is_periph;
	assign periph_re = acc_rd && is_periph;

	always_comb begin
		next_rdata = 8'h00;
		case (space)
			BMMD_SPACE_CORE: begin
				case (eff_ofs)
					BMMD_OFS_PCL: next_rdata = pc[7:0];
					BMMD_OFS_STATUS: next_rdata = core_status;
					BMMD_OFS_POINTER: next_rdata = indirect_pointer;
					BMMD_OFS_PCUB: next_rdata = {3'h0, program_counter_upper_buffer};
					default: next_rdata = 8'h00;
				endcase
			end
			BMMD_SPACE_OTHER: begin
				if (is_gp) begin
					next_rdata = gp_ram[ram_idx];
				end else if (periph_hit && is_periph) begin
					next_rdata = periph_rdata;
				end
			end
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (acc_wr && is_gp) begin
			gp_ram[ram_idx] <= data_req.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_rsp <= '0;
		end else begin
			data_rsp.valid <= data_req.en;
			data_rsp.rdata <= acc_rd ? next_rdata : 8'h00;
		end
	end

	// core-side flag updates yield to a software write in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_status <= BMMD_STATUS_RESET;
		end else if (acc_wr && is_core && eff_ofs == BMMD_OFS_STATUS) begin
			core_status <= {data_req.wdata[7:5], core_status[4:3], data_req.wdata[2:0]};
		end else if (status_flags_we) begin
			core_status <= {core_status[7:5], status_flags_in};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			indirect_pointer <= BMMD_POINTER_RESET;
		end else if (acc_wr && is_core && eff_ofs == BMMD_OFS_POINTER) begin
			indirect_pointer <= data_req.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			program_counter_upper_buffer <= BMMD_PCUB_RESET;
		end else if (acc_wr && is_core && eff_ofs == BMMD_OFS_PCUB) begin
			program_counter_upper_buffer <= data_req.wdata[4:0];
		end
	end

	// priority: interrupt, jump, write to low counter byte, advance
	always_comb begin
		next_pc = pc;
		if (pc_ctl.irq) begin
			next_pc = BMMD_IRQ_VECTOR;
		end else if (pc_ctl.load) begin
			next_pc = pc_ctl.target;
		end else if (acc_wr && is_core && eff_ofs == BMMD_OFS_PCL) begin
			next_pc = {program_counter_upper_buffer, data_req.wdata};
		end else if (pc_ctl.advance) begin
			next_pc = BMMD_PC_W'(pc + 13'h0001);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= BMMD_RESET_VECTOR;
		end else begin
			pc <= next_pc;
		end
	end

	bmmd_prog_mem u_prog_mem (
		.clk(clk),
		.pc(pc),
		.load_en(prog_load_en),
		.load_addr(prog_load_addr),
		.load_data(prog_load_data),
		.instr(instr)
	);
endmodule

// file: verification/bmmd_checker.sv
// assertions on the decoder's counter and data ports
`timescale 1ns/100ps
module bmmd_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire bmmd_pkg::bmmd_pc_ctl_s pc_ctl,
	input wire logic [12:0] pc,
	input wire bmmd_pkg::bmmd_data_req_s data_req,
	input wire bmmd_pkg::bmmd_data_rsp_s data_rsp,
	input wire logic status_flags_we,
	input wire logic [7:0] core_status,
	input wire logic [7:0] indirect_pointer
);
	import bmmd_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire rdo = data_req.en && !data_req.we && !data_req.indirect && !core_status[6];
	wire stw = data_req.en && data_req.we && !data_req.indirect && data_req.ofs == 7'h03;
	wire stp = pc_ctl.advance && !pc_ctl.load && !pc_ctl.irq && !data_req.en;
	rsp_valid_a: assert property (data_req.en |=> data_rsp.valid)
		else $error("no answer");
	irq_vec_a: assert property (pc_ctl.irq |=> pc == 13'h0004)
		else $error("bad vector");
	pc_load_a: assert property (pc_ctl.load && !pc_ctl.irq |=> pc == $past(pc_ctl.target))
		else $error("bad load");
	pc_step_a: assert property (stp |=> pc == $past(pc) + 13'h1)
		else $error("bad step");
	ptr_mirror_a: assert property (rdo && data_req.ofs == 7'h04
		|=> data_rsp.rdata == $past(indirect_pointer)) else $error("bad mirror");
	hi_bank_a: assert property (data_req.en && core_status[6] |=> data_rsp.rdata == 8'h00)
		else $error("hi bank data");
	gp_hole_a: assert property (rdo && core_status[5] && data_req.ofs[6]
		|=> data_rsp.rdata == 8'h00) else $error("hole data");
	flags_ro_a: assert property (!status_flags_we |=> $stable(core_status[4:3]))
		else $error("flags moved");
	bank_sel_a: assert property (stw && !core_status[6]
		|=> core_status[6:5] == $past(data_req.wdata[6:5])) else $error("bank not set");
	cover property (pc_ctl.irq);
	cover property (stw ##1 rdo);
	cover property (data_req.en && data_req.indirect);
endmodule

// file: verification/bmmd_core_model.sv
// core stand-in: one data access at a time
`timescale 1ns/100ps
module bmmd_core_model (
	input wire logic clk,
	output bmmd_pkg::bmmd_data_req_s data_req,
	input wire bmmd_pkg::bmmd_data_rsp_s data_rsp
);
	import bmmd_pkg::*;
	bit allow_hi = 1'b0;
	initial data_req = '0;
	task automatic access(input logic we, input logic ind, input logic [6:0] ofs,
		input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clk);
		if (we && !ind && ofs == BMMD_OFS_STATUS && !allow_hi) begin
			wd[6] = 1'b0;
		end
		data_req <= '{1'b1, we, ind, ofs, wd};
		@(posedge clk);
		// released fields flip so stale values cannot pass for live ones
		data_req <= '{1'b0, ~we, ~ind, ~ofs, ~wd};
		#1;
		rd = data_rsp.rdata;
	endtask
endmodule

// file: verification/tb.sv
// bench for the memory map decoder with a reference data map
`timescale 1ns/100ps
module tb;
	import bmmd_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ld = 1'b0;
	bmmd_pc_ctl_s pc_ctl = '0;
	bmmd_data_req_s data_req;
	bmmd_data_rsp_s data_rsp;
	logic [12:0] pc;
	logic [13:0] instr;
	logic [7:0] core_status, indirect_pointer, rd, a, rnd = 8'h34;
	logic flags_we = 1'b0;
	logic [4:0] flags_in = 5'h00;
	logic [7:0] p_addr, p_wdata;
	logic [7:0] p_seen = 8'h00;
	logic p_we, p_re;
	wire p_hit = p_re && p_addr == 8'h85;
	int miscompares = 0;
	int check_count = 0;
	int ref_ram [256];
	logic [7:0] addr_q [$];
	initial forever #25 clk = ~clk;
	bmmd_decoder i_dut (.clk, .rst_n, .pc_ctl, .pc, .instr, .prog_load_en(ld),
		.prog_load_addr(11'h005), .prog_load_data({6'h2a, rnd}), .data_req, .data_rsp,
		.status_flags_we(flags_we), .status_flags_in(flags_in), .core_status, .indirect_pointer,
		.periph_addr(p_addr), .periph_we(p_we), .periph_re(p_re), .periph_wdata(p_wdata),
		.periph_rdata(8'h5a), .periph_hit(p_hit));
	bmmd_core_model i_core (.clk, .data_req, .data_rsp);
	// peripheral stand-in: answers only at 85h and latches writes there
	always @(posedge clk) begin
		if (p_we && p_addr == 8'h85) begin
			p_seen <= p_wdata;
		end
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic pcs(input bmmd_pc_ctl_s c);
		@(posedge clk);
		pc_ctl <= c;
		@(posedge clk);
		pc_ctl <= '0;
		#1;
	endtask
	// bank is picked by a status write first, so every access costs two
	task automatic acc(input logic w, input logic i, input logic [7:0] o, input logic [7:0] d);
		i_core.access(1'b1, 1'b0, 7'h03, {2'b00, o[7], 5'h00}, rd);
		i_core.access(w, i, o[6:0], d, rd);
	endtask
	initial begin
		#(50 * 20000);
		miscompares++;
		test_done;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		ld <= 1'b1;
		check(16'(pc), 16'h0000);
		check(16'(core_status), 16'h0018);
		pcs('{1'b1, 13'h0805, 1'b0, 1'b0});
		@(posedge clk);
		ld <= 1'b0;
		#1;
		check(16'(instr), 16'({6'h2a, rnd}));
		pcs('{1'b1, 13'h1fff, 1'b0, 1'b0});
		pcs('{1'b0, 13'h0000, 1'b1, 1'b0});
		check(16'(pc), 16'h0000);
		pcs('{1'b1, 13'h0100, 1'b1, 1'b1});
		check(16'(pc), 16'h0004);
		acc(1'b1, 1'b0, 8'h02, 8'h33);
		check(16'(pc), 16'h0033);
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			a = {i[0], 7'h20 + 7'(rnd % 96)};
			rnd = lfsr(rnd);
			acc(1'b1, 1'b0, a, rnd);
			if (a < 8'hc0)
				ref_ram[a] = rnd;
			addr_q.push_back(a);
		end
		foreach (addr_q[k]) begin
			acc(1'b0, 1'b0, addr_q[k], 8'h00);
			check(16'(rd), 16'(ref_ram[addr_q[k]]));
		end
		acc(1'b1, 1'b0, 8'h04, 8'ha5);
		check(16'(indirect_pointer), 16'h00a5);
		acc(1'b0, 1'b0, 8'h84, 8'h00);
		check(16'(rd), 16'h00a5);
		acc(1'b1, 1'b1, 8'h11, 8'h3c);
		acc(1'b0, 1'b0, 8'ha5, 8'h00);
		check(16'(rd), 16'h003c);
		acc(1'b0, 1'b0, 8'h00, 8'h00);
		check(16'(rd), 16'h003c);
		acc(1'b0, 1'b0, 8'h08, 8'h00);
		check(16'(rd), 16'h0000);
		@(posedge clk);
		flags_we <= 1'b1;
		flags_in <= 5'h1a;
		@(posedge clk);
		flags_we <= 1'b0;
		#1;
		check(16'(core_status), 16'h001a);
		acc(1'b1, 1'b0, 8'h03, 8'hff);
		check(16'(core_status), 16'h00bf);
		acc(1'b1, 1'b0, 8'h85, 8'hc3);
		check(16'(p_seen), 16'h00c3);
		acc(1'b0, 1'b0, 8'h85, 8'h00);
		check(16'(rd), 16'h005a);
		i_core.allow_hi = 1'b1;
		i_core.access(1'b1, 1'b0, 7'h03, 8'h40, rd);
		check(16'(core_status[6:5]), 16'h0002);
		acc(1'b0, 1'b0, 8'h04, 8'h00);
		check(16'(rd), 16'h0000);
		test_done;
	end
endmodule
bind bmmd_decoder bmmd_checker i_chk (.clk, .rst_n, .pc_ctl, .pc, .data_req, .data_rsp,
	.status_flags_we, .core_status, .indirect_pointer);
